// File: dv/addr_decode_chk.sv
// bus-carrier checker for the requester and decoder pair
`timescale 1ns/1ps
`default_nettype none
module addr_decode_chk (
  // clock and reset
  input wire logic                clk,
  input wire logic                rst_b,
  // bus carrier
  input wire logic                reqValid,
  input wire logic [31:0]         addr,
  input wire addr_map_pkg::size_t size,
  input wire logic                ackValid,
  input wire logic                busErrB
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  // ---------------------------------------------------------------
  // addresses that no target owns
  // ---------------------------------------------------------------
  wire unmapped = (addr >= 32'h0300_0000 && addr <= 32'h0FFF_FFFF) || addr > 32'h1FFF_FFFF;
  sequence newMiss;
    $rose(reqValid) && unmapped;
  endsequence
  sequence errAck;
    (ackValid && !busErrB) ##1 !ackValid;
  endsequence
  miss_err_a: assert property (newMiss |=> errAck)
    else $error("unmapped request not answered with a bus error");
  reset_idle_a: assert property ($rose(rst_b) |-> !reqValid && !ackValid && busErrB)
    else $error("bus not idle after reset");
  half_align_a: assert property (reqValid && size == addr_map_pkg::SZ_HALF |-> !addr[0])
    else $error("odd half-word request on the bus");
  word_align_a: assert property (reqValid && size == addr_map_pkg::SZ_WORD |-> addr[1:0] == 2'h0)
    else $error("unaligned word request on the bus");
  req_hold_a: assert property (reqValid && !ackValid |=> reqValid && $stable(addr) && $stable(size))
    else $error("request changed before its answer");
  req_drop_a: assert property (ackValid |=> !reqValid)
    else $error("request held past its answer");
  ack_req_a: assert property (ackValid |-> reqValid)
    else $error("answer without a request");
  ack_pulse_a: assert property (ackValid |=> !ackValid)
    else $error("answer longer than one cycle");
endmodule
`default_nettype wire

// File: dv/tb_top.sv
// bench joining requester and decoder back to back
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic                  clk = 1'b0, rst_b = 1'b0, cmdValid = 1'b0, cmdWrite = 1'b0;
  logic                  parityBypass = 1'b0, tgtErrB = 1'b1, tgtParityErrB = 1'b1;
  logic                  tgtDone = 1'b0, served = 1'b0;
  logic                  cmdReady, cmdMisalignB, rspValid, rspErrB, masterConflictB;
  // masters only ever sit in slots four and five
  logic [1:0]            slotMasterB = 2'h3;
  logic [3:0]            laneEnB, seenLane;
  logic [5:0]            slotSelB, seenSel;
  logic [31:0]           cmdAddr = 32'h0, cmdData = 32'h0, tgtRdata = 32'h0;
  logic [31:0]           rspData, tgtWdata, seenWd, tgtAddr, seenAddr;
  logic                  tgtWrite, seenWr;
  addr_map_pkg::size_t   cmdSize = addr_map_pkg::SZ_BYTE;
  addr_map_pkg::size_t   tgtSize, seenSz;
  addr_map_pkg::target_t target, seenTgt;
  int                    bad_count = 0, checks_done = 0, cycles = 0, cnt = 0, tgtWait = 0;
  always #2 clk = ~clk;
  phys_bus_if busIf ();
  bus_requester bus_requester_i (.clk(clk), .rst_b(rst_b), .cmdValid(cmdValid),
    .cmdAddr(cmdAddr), .cmdSize(cmdSize), .cmdWrite(cmdWrite), .cmdData(cmdData),
    .cmdReady(cmdReady), .cmdMisalignB(cmdMisalignB), .rspValid(rspValid),
    .rspErrB(rspErrB), .rspData(rspData), .bus(busIf.requester));
  phys_addr_decoder phys_addr_decoder_i (.clk(clk), .rst_b(rst_b), .bus(busIf.decoder),
    .parityBypass(parityBypass), .slotMasterB(slotMasterB), .masterConflictB(masterConflictB),
    .target(target), .slotSelB(slotSelB), .tgtAddr(tgtAddr), .tgtWrite(tgtWrite),
    .tgtSize(tgtSize),
    .laneEnB(laneEnB), .tgtWdata(tgtWdata), .tgtDone(tgtDone), .tgtErrB(tgtErrB),
    .tgtParityErrB(tgtParityErrB), .tgtRdata(tgtRdata));
  addr_decode_chk addr_decode_chk_i (.clk(clk), .rst_b(rst_b), .reqValid(busIf.reqValid),
    .addr(busIf.addr), .size(busIf.size), .ackValid(busIf.ackValid), .busErrB(busIf.busErrB));
  // ---------------------------------------------------------------
  // far target: answers once per select, after tgtWait cycles
  // ---------------------------------------------------------------
  wire hit = target !== addr_map_pkg::TGT_NONE;
  wire fire = hit && !served && cnt == tgtWait;
  always @(posedge clk) begin
    tgtDone <= fire;
    served <= hit && (served || fire);
    cnt <= (hit && !served) ? cnt + 1 : 0;
    if (fire) begin
      seenTgt <= target;
      seenSel <= slotSelB;
      seenLane <= laneEnB;
      seenWd <= tgtWdata;
      seenAddr <= tgtAddr;
      seenWr <= tgtWrite;
      seenSz <= tgtSize;
    end
  end
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      bad_count++;
      end_sim();
    end
  end
  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic op(input logic [31:0] a, input addr_map_pkg::size_t s, input logic w);
    int n;
    n = 0;
    seenTgt <= addr_map_pkg::TGT_NONE;
    seenSel <= 6'h3F;
    cmdAddr <= a;
    cmdSize <= s;
    cmdWrite <= w;
    cmdValid <= 1'b1;
    @(negedge clk);
    chk(cmdMisalignB, 1'b1);
    chk(cmdReady, 1'b1);
    @(posedge clk);
    cmdValid <= 1'b0;
    @(negedge clk);
    chk(cmdReady, 1'b0);
    do @(negedge clk); while (rspValid !== 1'b1 && ++n < 40);
    chk(n < 40, 1'b1);
    @(posedge clk);
  endtask
  task automatic t_map();
    logic [31:0] a [14] = '{32'h0, 32'h0080_0000, 32'h02FF_FFFC, 32'h0300_0000,
      32'h07FF_FFFC, 32'h0800_0000, 32'h1000_0000, 32'h17FF_FFFC, 32'h1800_0000,
      32'h1CFF_FFFC, 32'h1D00_0000, 32'h1E00_0000, 32'h1FFF_FFFC, 32'h2000_0000};
    logic [5:0] t [14] = '{6'h01, 6'h01, 6'h01, 6'h00, 6'h00, 6'h00, 6'h02, 6'h02,
      6'h04, 6'h04, 6'h08, 6'h10, 6'h20, 6'h00};
    for (int i = 0; i < 14; i++) begin
      op(a[i], addr_map_pkg::SZ_WORD, 1'b0);
      chk(seenTgt, t[i]);
      chk(seenSel, t[i] == 6'h01 ? 6'(~(6'h01 << a[i][25:23])) : 6'h3F);
      chk(rspErrB, t[i] != 6'h00);
    end
    $display("map test done");
  endtask
  task automatic t_lanes();
    tgtRdata <= 32'h1122_3344;
    for (int k = 0; k < 4; k++) begin
      cmdData <= 32'hA5;
      op(32'h100 + k, addr_map_pkg::SZ_BYTE, 1'b1);
      chk(seenLane, 4'(~(4'h8 >> k)));
      chk(seenWd[31-8*k -: 8], 8'hA5);
      chk(seenAddr, 32'h100 + k);
      chk({seenWr, seenSz}, {1'b1, addr_map_pkg::SZ_BYTE});
      op(32'h100 + k, addr_map_pkg::SZ_BYTE, 1'b0);
      chk(rspData[7:0], 32'h11 * (k + 1));
    end
    for (int k = 0; k < 2; k++) begin
      cmdData <= 32'hBEEF;
      op(32'h100 + 2 * k, addr_map_pkg::SZ_HALF, 1'b1);
      chk(seenLane, k ? 4'hC : 4'h3);
      chk(seenWd[31-16*k -: 16], 16'hBEEF);
      op(32'h100 + 2 * k, addr_map_pkg::SZ_HALF, 1'b0);
      chk(rspData[15:0], k ? 32'h3344 : 32'h1122);
    end
    cmdData <= 32'hCAFE_F00D;
    op(32'h104, addr_map_pkg::SZ_WORD, 1'b1);
    chk(seenWd, 32'hCAFE_F00D);
    chk(seenLane, 4'h0);
    chk({seenWr, seenSz}, {1'b1, addr_map_pkg::SZ_WORD});
    $display("lane test done");
  endtask
  task automatic t_misalign();
    for (int i = 0; i < 2; i++) begin
      cmdAddr <= i ? 32'h102 : 32'h101;
      cmdSize <= i ? addr_map_pkg::SZ_WORD : addr_map_pkg::SZ_HALF;
      cmdValid <= 1'b1;
      @(negedge clk);
      chk(cmdMisalignB, 1'b0);
      @(posedge clk);
      cmdValid <= 1'b0;
      repeat (3) @(negedge clk);
      chk(busIf.reqValid, 1'b0);
      @(posedge clk);
    end
    $display("alignment test done");
  endtask
  task automatic t_errs();
    // bits: target error, parity error, bypass, expected answer
    logic [3:0] v [4] = '{4'b0100, 4'b1000, 4'b1011, 4'b0110};
    for (int i = 0; i < 4; i++) begin
      tgtErrB <= v[i][3];
      tgtParityErrB <= v[i][2];
      parityBypass <= v[i][1];
      tgtWait <= 3;
      op(32'h0, addr_map_pkg::SZ_WORD, 1'b0);
      chk(rspErrB, v[i][0]);
    end
    tgtErrB <= 1'b1;
    tgtParityErrB <= 1'b1;
    parityBypass <= 1'b0;
    tgtWait <= 0;
    for (int i = 0; i < 4; i++) begin
      slotMasterB <= 2'(i);
      @(negedge clk);
      chk(masterConflictB, i != 0);
      @(posedge clk);
    end
    $display("error and master test done");
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    t_map();
    t_lanes();
    t_misalign();
    t_errs();
    end_sim();
  end
endmodule
`default_nettype wire

// File: src/addr_map_pkg.sv
// address map constants for the physical address decoder
package addr_map_pkg;
  localparam int unsigned AW = 32;
  localparam int unsigned DW = 32;
  localparam int unsigned SLOTS = 6;
  localparam logic [31:0] MAIN_SPACE_TOP = 32'h07FF_FFFF;
  localparam logic [31:0] POP_MEM_TOP = 32'h02FF_FFFF;
  localparam int unsigned SLOT_SHIFT = 23;
  localparam logic [31:0] EXP_BASE = 32'h1000_0000;
  localparam logic [31:0] EXP_TOP = 32'h17FF_FFFF;
  localparam logic [31:0] LIO_BASE = 32'h1800_0000;
  localparam logic [31:0] LIO_TOP = 32'h1CFF_FFFF;
  localparam logic [31:0] NET_PROM_BASE = 32'h1D00_0000;
  localparam logic [31:0] ID_PROM_BASE = 32'h1E00_0000;
  localparam logic [31:0] BOOT_PROM_BASE = 32'h1F00_0000;
  localparam logic [31:0] PROM_TOP = 32'h1FFF_FFFF;
  localparam logic [2:0] SLOT_NONE = 3'h7;
  // access sizes
  typedef enum logic [1:0] {
    SZ_BYTE = 2'h0,
    SZ_HALF = 2'h1,
    SZ_WORD = 2'h2
  } size_t;
  // one-hot target codes
  typedef enum logic [5:0] {
    TGT_NONE = 6'h00,
    TGT_MEM  = 6'h01,
    TGT_EXP  = 6'h02,
    TGT_LIO  = 6'h04,
    TGT_NETP = 6'h08,
    TGT_IDP  = 6'h10,
    TGT_BOOT = 6'h20
  } target_t;
  localparam logic [1:0] HALF_ALIGN_MASK = 2'h1;
  localparam logic [1:0] WORD_ALIGN_MASK = 2'h3;
endpackage

// File: src/bus_requester.sv
// processor-side end: refuses misaligned requests and places bytes big-endian
`timescale 1ns/1ps
`default_nettype none
module bus_requester (
  // clock and reset
  input  wire logic                clk,
  input  wire logic                rst_b,
  // user side
  input  wire logic                cmdValid,
  input  wire logic [31:0]         cmdAddr,
  input  wire addr_map_pkg::size_t cmdSize,
  input  wire logic                cmdWrite,
  input  wire logic [31:0]         cmdData,
  output logic                     cmdReady,
  output logic                     cmdMisalignB,
  output logic                     rspValid,
  output logic                     rspErrB,
  output logic [31:0]              rspData,
  // bus
  phys_bus_if.requester            bus
);
  logic        busy_q;
  logic [31:0] addr_q;
  logic [31:0] wdata_q;
  logic        write_q;
  addr_map_pkg::size_t size_q;
  logic        rspValid_q;
  logic        rspErrB_q;
  logic [31:0] rspData_q;
  // ----------------------------------------
  // alignment check before issue
  // ----------------------------------------
  wire misHalf = (cmdSize == addr_map_pkg::SZ_HALF) &&
                 ((cmdAddr[1:0] & addr_map_pkg::HALF_ALIGN_MASK) != 2'h0);
  wire misWord = (cmdSize == addr_map_pkg::SZ_WORD) &&
                 ((cmdAddr[1:0] & addr_map_pkg::WORD_ALIGN_MASK) != 2'h0);
  wire misaligned = misHalf || misWord;
  assign cmdReady = !busy_q;
  assign cmdMisalignB = !(cmdValid && misaligned);
  wire issue = cmdValid && !busy_q && !misaligned;
  // item placed at lane of its most significant byte, byte 0 leftmost
  wire [4:0] laneShift = {cmdAddr[1:0], 3'h0};
  wire [31:0] laneData =
    (cmdSize == addr_map_pkg::SZ_WORD) ? cmdData :
    (cmdSize == addr_map_pkg::SZ_HALF) ? ({cmdData[15:0], 16'h0000} >> laneShift) :
    ({cmdData[7:0], 24'h00_0000} >> laneShift);
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      busy_q <= 1'b0;
      addr_q <= 32'h0000_0000;
      wdata_q <= 32'h0000_0000;
      write_q <= 1'b0;
      size_q <= addr_map_pkg::SZ_BYTE;
    end else if (issue) begin
      busy_q <= 1'b1;
      addr_q <= cmdAddr;
      wdata_q <= laneData;
      write_q <= cmdWrite;
      size_q <= cmdSize;
    end else if (bus.ackValid) begin
      busy_q <= 1'b0;
    end
  end
  assign bus.reqValid = busy_q;
  assign bus.addr = addr_q;
  assign bus.size = size_q;
  assign bus.write = write_q;
  assign bus.wdata = wdata_q;
  // ----------------------------------------
  // answer back to user, read data taken from lanes
  // ----------------------------------------
  wire [4:0] rdShift = {addr_q[1:0], 3'h0};
  wire [31:0] rdAligned = bus.rdata << rdShift;
  wire [31:0] rdItem =
    (size_q == addr_map_pkg::SZ_WORD) ? bus.rdata :
    (size_q == addr_map_pkg::SZ_HALF) ? {16'h0000, rdAligned[31:16]} :
    {24'h00_0000, rdAligned[31:24]};
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      rspValid_q <= 1'b0;
      rspErrB_q <= 1'b1;
      rspData_q <= 32'h0000_0000;
    end else begin
      rspValid_q <= busy_q && bus.ackValid;
      if (busy_q && bus.ackValid) begin
        rspErrB_q <= bus.busErrB;
        rspData_q <= rdItem;
      end
    end
  end
  assign rspValid = rspValid_q;
  assign rspErrB = rspErrB_q;
  assign rspData = rspData_q;
endmodule
`default_nettype wire

// File: src/phys_addr_decoder.sv
// physical address decoder: steers each mapped bus cycle to one target, answers unmapped ones with a bus error
`timescale 1ns/1ps
`default_nettype none
module phys_addr_decoder (
  // clock and reset
  input  wire logic                    clk,
  input  wire logic                    rst_b,
  // bus
  phys_bus_if.decoder                  bus,
  // configuration
  input  wire logic                    parityBypass,
  input  wire logic [1:0]              slotMasterB,
  output logic                         masterConflictB,
  // target selects
  output addr_map_pkg::target_t        target,
  output logic [addr_map_pkg::SLOTS-1:0] slotSelB,
  output logic [31:0]                  tgtAddr,
  output logic                         tgtWrite,
  output addr_map_pkg::size_t          tgtSize,
  output logic [3:0]                   laneEnB,
  output logic [31:0]                  tgtWdata,
  // target answer
  input  wire logic                    tgtDone,
  input  wire logic                    tgtErrB,
  input  wire logic                    tgtParityErrB,
  input  wire logic [31:0]             tgtRdata
);
  // ----------------------------------------
  // state machine
  // ----------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_WAIT = 3'b010,
    ST_ACK  = 3'b100
  } state_t;
  state_t state_q;
  state_t state_d;
  addr_map_pkg::target_t target_q;
  logic [addr_map_pkg::SLOTS-1:0] slotSelB_q;
  logic [31:0] tgtAddr_q;
  logic [31:0] tgtWdata_q;
  logic tgtWrite_q;
  addr_map_pkg::size_t tgtSize_q;
  logic [3:0] laneEnB_q;
  logic busErrB_q;
  logic [31:0] rdata_q;
  // ----------------------------------------
  // address decode
  // ----------------------------------------
  wire [31:0] a = bus.addr;
  wire inMainSpace = a <= addr_map_pkg::MAIN_SPACE_TOP;
  wire inPopMem = a <= addr_map_pkg::POP_MEM_TOP;
  wire [2:0] slotIdx = a[addr_map_pkg::SLOT_SHIFT+2:addr_map_pkg::SLOT_SHIFT];
  wire inExp = (a >= addr_map_pkg::EXP_BASE) && (a <= addr_map_pkg::EXP_TOP);
  wire inLio = (a >= addr_map_pkg::LIO_BASE) && (a <= addr_map_pkg::LIO_TOP);
  wire inBoot = (a >= addr_map_pkg::BOOT_PROM_BASE) && (a <= addr_map_pkg::PROM_TOP);
  wire inId = (a >= addr_map_pkg::ID_PROM_BASE) && (a < addr_map_pkg::BOOT_PROM_BASE);
  wire inNet = (a >= addr_map_pkg::NET_PROM_BASE) && (a < addr_map_pkg::ID_PROM_BASE);
  addr_map_pkg::target_t decTarget;
  assign decTarget =
    (inMainSpace && inPopMem) ? addr_map_pkg::TGT_MEM :
    inExp  ? addr_map_pkg::TGT_EXP :
    inLio  ? addr_map_pkg::TGT_LIO :
    inNet  ? addr_map_pkg::TGT_NETP :
    inId   ? addr_map_pkg::TGT_IDP :
    inBoot ? addr_map_pkg::TGT_BOOT :
    addr_map_pkg::TGT_NONE;
  // one window per slot position, active low selects
  wire [addr_map_pkg::SLOTS-1:0] decSlotB;
  genvar g;
  generate
    for (g = 0; g < addr_map_pkg::SLOTS; g++) begin : g_slot
      assign decSlotB[g] = !((decTarget == addr_map_pkg::TGT_MEM) &&
                             (slotIdx == 3'(g)));
    end
  endgenerate
  // byte lanes: lane 3 is bits 31:24, byte zero
  wire [3:0] laneMask =
    (bus.size == addr_map_pkg::SZ_WORD) ? 4'hF :
    (bus.size == addr_map_pkg::SZ_HALF) ? (4'hC >> a[1:0]) :
    (4'h8 >> a[1:0]);
  // two masters in slots four and five is a config fault
  assign masterConflictB = !(slotMasterB == 2'h0);
  // ----------------------------------------
  // cycle control
  // ----------------------------------------
  wire take = (state_q == ST_IDLE) && bus.reqValid;
  wire miss = decTarget == addr_map_pkg::TGT_NONE;
  // a bypassed parity error is not reported, real errors still are
  wire doneErrB = tgtErrB && (tgtParityErrB || parityBypass);
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (bus.reqValid) begin
          state_d = miss ? ST_ACK : ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (tgtDone) begin
          state_d = ST_ACK;
        end
      end
      ST_ACK: begin
        state_d = ST_IDLE;
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      state_q <= ST_IDLE;
      target_q <= addr_map_pkg::TGT_NONE;
      slotSelB_q <= '1;
      tgtAddr_q <= 32'h0000_0000;
      tgtWdata_q <= 32'h0000_0000;
      tgtWrite_q <= 1'b0;
      tgtSize_q <= addr_map_pkg::SZ_BYTE;
      laneEnB_q <= 4'hF;
      busErrB_q <= 1'b1;
      rdata_q <= 32'h0000_0000;
    end else begin
      state_q <= state_d;
      if (take && !miss) begin
        target_q <= decTarget;
        slotSelB_q <= decSlotB;
        tgtAddr_q <= a;
        tgtWdata_q <= bus.wdata;
        tgtWrite_q <= bus.write;
        tgtSize_q <= bus.size;
        laneEnB_q <= ~laneMask;
      end else if (take && miss) begin
        busErrB_q <= 1'b0;
        rdata_q <= 32'h0000_0000;
      end else if ((state_q == ST_WAIT) && tgtDone) begin
        target_q <= addr_map_pkg::TGT_NONE;
        slotSelB_q <= '1;
        laneEnB_q <= 4'hF;
        busErrB_q <= doneErrB;
        rdata_q <= tgtRdata;
      end else if (state_q == ST_ACK) begin
        busErrB_q <= 1'b1;
      end
    end
  end
  assign target = target_q;
  assign slotSelB = slotSelB_q;
  assign tgtAddr = tgtAddr_q;
  assign tgtWdata = tgtWdata_q;
  assign tgtWrite = tgtWrite_q;
  assign tgtSize = tgtSize_q;
  assign laneEnB = laneEnB_q;
  assign bus.ackValid = state_q == ST_ACK;
  assign bus.busErrB = busErrB_q;
  assign bus.rdata = rdata_q;
endmodule
`default_nettype wire

// File: src/phys_bus_if.sv
// processor-to-decoder physical bus carrier
`timescale 1ns/1ps
`default_nettype none
interface phys_bus_if;
  logic                          reqValid;
  logic [31:0]                   addr;
  addr_map_pkg::size_t           size;
  logic                          write;
  logic [31:0]                   wdata;
  logic                          ackValid;
  logic                          busErrB;
  logic [31:0]                   rdata;
  modport requester (output reqValid, addr, size, write, wdata,
                     input ackValid, busErrB, rdata);
  modport decoder (input reqValid, addr, size, write, wdata,
                   output ackValid, busErrB, rdata);
endinterface
`default_nettype wire
